// *** sdi_dac_input.sv ***
// The placing of the registers and the strobed register port were decided locally.
`include "sdi_cfg.svh"

module sdi_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready_o  = (wr_ptr[AW] == rd_ptr[AW]) ||
                       (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
  assign out_valid_o = wr_ptr != rd_ptr;
  assign out_data_o  = mem[rd_ptr[AW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule : sdi_fifo

////////////////////////////////////////////////////////////////////////////
// Behaviour
// - reset low: low power, defaults; high: operate
// - host mode reset low restores all registers
// - control port ignored while reset low
// - host clears power-down before conversion starts
// - host re-enables host port after every reset
// - reset held low until clocks stable
// - two's complement words, MSB first, bit clocked
// - frame level picks channel, runs at rate
// - left/right pair output together; right/left skewed
// - single speed master clock 256x to 1024x
// - double speed master clock 128x to 512x
// - quad speed master clock 64x to 256x
// - top ratio only in host port mode
// - power-down reads set; registers kept meanwhile
// - host writes 30h to register 5 early
// - divide-by-2 bit unlocks higher master clock rates
// - mute outputs during reset, power-down, bad ratio
module sdi_dac_input #(
  parameter logic [7:0] CHIP_ID = 8'hA5  // arbitrary identification value
) (
  // clock and reset
  input  wire logic          clk_sys_i,
  input  wire logic          rst_i,
  // link to the audio source
  sdi_link_if.dev            lnk,
  // sample pairs out
  input  wire logic          sample_ready_i,
  output logic               sample_valid_o,
  output sdi_pkg::sdi_word_t sample_left_o,
  output sdi_pkg::sdi_word_t sample_right_o,
  // status
  output logic               chan_a_mute_out_o,
  output logic               chan_b_mute_out_o,
  output logic               running_o,
  output logic               overrun_o
);
  logic [7:0]         mode2;
  logic               host_port_enable_bit;
  logic               power_down_bit;
  logic               mclk_div_bit;
  logic               in_reset;
  logic               bclk_q;
  logic               mclk_q;
  logic               frame_q;
  logic               bclk_rise;
  logic               mclk_rise;
  logic               frame_rise;
  logic [10:0]        mclk_cnt;
  logic               ratio_ok;
  logic               running;
  sdi_pkg::sdi_word_t shreg;
  sdi_pkg::sdi_word_t held_left;
  logic [4:0]         bit_cnt;
  logic               lr_prev;
  logic               synced;
  logic               have_left;
  logic               pair_stb;
  logic [47:0]        pair_word;
  logic [47:0]        pend;
  logic               pend_valid;
  logic               fifo_ready;
  logic [47:0]        fifo_out;

  // valid master clock to frame ratio for the selected speed range
  function automatic logic ratio_valid(input logic [1:0]  speed,
                                       input logic [10:0] n,
                                       input logic        top_ok);
    logic [10:0] base;
    base = `SDI_BASE_RATIO >> speed;
    ratio_valid = (speed != sdi_pkg::SDI_SPEED_RSVD) &&
                  (n == base || n == base + (base >> 1) ||
                   n == {base[9:0], 1'b0} ||
                   n == base + {base[9:0], 1'b0} ||
                   (top_ok && n == {base[8:0], 2'b00}));
  endfunction : ratio_valid

  assign in_reset             = rst_i || !lnk.dac_reset_n;
  assign host_port_enable_bit = mode2[`SDI_HOST_PORT_ENABLE_BIT_BIT];
  assign power_down_bit       = mode2[`SDI_PDN_BIT];
  assign mclk_div_bit         = mode2[`SDI_MDIV_BIT];
  assign bclk_rise            = lnk.bit_clock && !bclk_q;
  assign mclk_rise            = lnk.master_clock && !mclk_q;
  assign frame_rise           = lnk.frame_select_clock && !frame_q;
  // conversion needs reset high and, in host port mode, power-down clear
  assign running = !in_reset && ratio_ok &&
                   (!host_port_enable_bit || !power_down_bit);

  ////////////////////////////////////////////////////////////////////////////
  // control port
  always_ff @(posedge clk_sys_i) begin
    if (in_reset) begin
      mode2 <= `SDI_MODE2_RST;
    end else if (lnk.cp_wr && lnk.cp_addr == `SDI_MODE2_IDX) begin
      mode2 <= lnk.cp_wdata & `SDI_MODE2_MASK;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (in_reset || !lnk.cp_rd) begin
      lnk.cp_rdata <= 8'h00;
    end else if (lnk.cp_addr == `SDI_MODE2_IDX) begin
      lnk.cp_rdata <= mode2;
    end else if (lnk.cp_addr == `SDI_CHIPID_IDX) begin
      lnk.cp_rdata <= CHIP_ID;
    end else begin
      lnk.cp_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edge detect and clock ratio check
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      bclk_q  <= 1'b0;
      mclk_q  <= 1'b0;
      frame_q <= 1'b0;
    end else begin
      bclk_q  <= lnk.bit_clock;
      mclk_q  <= lnk.master_clock;
      frame_q <= lnk.frame_select_clock;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (in_reset) begin
      mclk_cnt <= 11'h000;
      ratio_ok <= 1'b0;
    end else if (frame_rise) begin
      ratio_ok <= ratio_valid(lnk.speed, mclk_cnt,
                   host_port_enable_bit && mclk_div_bit);
      mclk_cnt <= {10'h000, mclk_rise};
    end else if (mclk_cnt == `SDI_CNT_MAX) begin
      ratio_ok <= 1'b0;
    end else begin
      mclk_cnt <= mclk_cnt + {10'h000, mclk_rise};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      chan_a_mute_out_o <= 1'b1;
      chan_b_mute_out_o <= 1'b1;
      running_o         <= 1'b0;
    end else begin
      chan_a_mute_out_o <= !running;
      chan_b_mute_out_o <= !running;
      running_o         <= running;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial receiver and channel pairing
  always_ff @(posedge clk_sys_i) begin
    if (!running) begin
      shreg     <= '0;
      held_left <= '0;
      bit_cnt   <= 5'd`SDI_WORD_BITS;
      lr_prev   <= lnk.frame_select_clock;
      synced    <= 1'b0;
      have_left <= 1'b0;
      pair_stb  <= 1'b0;
      pair_word <= '0;
    end else begin
      pair_stb <= 1'b0;
      if (bclk_rise) begin
        lr_prev <= lnk.frame_select_clock;
        if (lnk.frame_select_clock != lr_prev) begin
          synced  <= 1'b1;
          shreg   <= {23'h000000, lnk.serial_audio_in};
          bit_cnt <= 5'd1;
          if (synced && lr_prev) begin
            held_left <= shreg;
            have_left <= 1'b1;
          end else if (synced && have_left) begin
            pair_word <= {held_left, shreg};
            pair_stb  <= 1'b1;
            have_left <= 1'b0;
          end
        end else if (bit_cnt != 5'd`SDI_WORD_BITS) begin
          shreg   <= {shreg[22:0], lnk.serial_audio_in};
          bit_cnt <= bit_cnt + 5'd1;
        end
      end
    end
  end

  // a pair waits here while the FIFO is full; a newer pair overwrites it
  always_ff @(posedge clk_sys_i) begin
    if (in_reset) begin
      pend       <= '0;
      pend_valid <= 1'b0;
      overrun_o  <= 1'b0;
    end else if (pair_stb) begin
      pend       <= pair_word;
      pend_valid <= 1'b1;
      if (pend_valid && !fifo_ready) begin
        overrun_o <= 1'b1;
      end
    end else if (fifo_ready) begin
      pend_valid <= 1'b0;
    end
  end

  sdi_fifo #(
    .WIDTH (48),
    .DEPTH (16)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .in_valid_i  (pend_valid),
    .in_ready_o  (fifo_ready),
    .in_data_i   (pend),
    .out_valid_o (sample_valid_o),
    .out_ready_i (sample_ready_i),
    .out_data_o  (fifo_out)
  );

  assign sample_left_o  = fifo_out[47:24];
  assign sample_right_o = fifo_out[23:0];
endmodule : sdi_dac_input

// *** sdi_cfg.svh ***
`ifndef SDI_CFG_SVH
`define SDI_CFG_SVH

////////////////////////////////////////////////////////////////////////////
// device control port map
`define SDI_MODE2_IDX     3'h5
`define SDI_CHIPID_IDX    3'h7
`define SDI_MODE2_RST     8'h10
`define SDI_MODE2_MASK    8'hFE
`define SDI_HOST_PORT_ENABLE_BIT_BIT      5
`define SDI_PDN_BIT       4
`define SDI_MDIV_BIT      1
`define SDI_CP_START      8'h30
`define SDI_CP_RUN        8'h20

////////////////////////////////////////////////////////////////////////////
// controller register map
`define SDI_REG_CTRL      3'h0
`define SDI_REG_RATIO     3'h1
`define SDI_REG_LEFT      3'h2
`define SDI_REG_RIGHT     3'h3
`define SDI_REG_STATUS    3'h4
`define SDI_CTRL_GO       0
`define SDI_CTRL_HOSTMODE 1
`define SDI_CTRL_MDIV     2
`define SDI_CTRL_SPD_LO   3
`define SDI_CTRL_RST      5'h00
`define SDI_RATIO_RST     11'h100

////////////////////////////////////////////////////////////////////////////
// serial framing
`define SDI_WORD_BITS     24
`define SDI_BASE_RATIO    11'h100
`define SDI_CNT_MAX       11'h7FF

////////////////////////////////////////////////////////////////////////////
// timing
`define SDI_CLK_MHZ       100
`define SDI_RST_HOLD_NS   200
`define SDI_RST_HOLD_CYC  ((`SDI_RST_HOLD_NS * `SDI_CLK_MHZ + 999) / 1000)

`endif

// *** sdi_pkg.sv ***
package sdi_pkg;

  typedef enum logic [1:0] {
    SDI_SPEED_SINGLE = 2'h0,
    SDI_SPEED_DOUBLE = 2'h1,
    SDI_SPEED_QUAD   = 2'h2,
    SDI_SPEED_RSVD   = 2'h3
  } sdi_speed_e;

  typedef enum logic [1:0] {
    SDI_ST_HOLD   = 2'h0,
    SDI_ST_WR_EN  = 2'h1,
    SDI_ST_WR_RUN = 2'h3,
    SDI_ST_RUN    = 2'h2
  } sdi_host_state_e;

  typedef logic [23:0] sdi_word_t;

endpackage : sdi_pkg

// *** sdi_link_if.sv ***
interface sdi_link_if;
  logic                   dac_reset_n;
  logic                   serial_audio_in;
  logic                   bit_clock;
  logic                   frame_select_clock;
  logic                   master_clock;
  sdi_pkg::sdi_speed_e    speed;
  logic                   cp_wr;
  logic                   cp_rd;
  logic [2:0]             cp_addr;
  logic [7:0]             cp_wdata;
  logic [7:0]             cp_rdata;

  modport src (
    output dac_reset_n, serial_audio_in, bit_clock, frame_select_clock,
    output master_clock, speed, cp_wr, cp_rd, cp_addr, cp_wdata,
    input  cp_rdata
  );

  modport dev (
    input  dac_reset_n, serial_audio_in, bit_clock, frame_select_clock,
    input  master_clock, speed, cp_wr, cp_rd, cp_addr, cp_wdata,
    output cp_rdata
  );
endinterface : sdi_link_if

// *** sdi_source.sv ***
`include "sdi_cfg.svh"

module sdi_source (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // software register port
  input  wire logic [2:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [31:0]      reg_rdata_o,
  // link to the converter
  sdi_link_if.src          lnk
);
  logic [4:0]                  ctrl;
  logic [10:0]                 ratio;
  sdi_pkg::sdi_word_t          left_w;
  sdi_pkg::sdi_word_t          right_w;
  sdi_pkg::sdi_word_t          cur_l;
  sdi_pkg::sdi_word_t          cur_r;
  sdi_pkg::sdi_word_t          word;
  sdi_pkg::sdi_host_state_e    state;
  logic [7:0]                  hold_cnt;
  logic [7:0]                  dev_mode2;
  logic                        rd_q;
  logic [4:0]                  hp;
  logic [4:0]                  hp_cnt;
  logic [5:0]                  slot;
  logic [5:0]                  nslot;

  assign hp    = (ratio[10:6] == 5'h00) ? 5'h01 : ratio[10:6];
  assign nslot = slot + 6'h01;
  assign word  = nslot[5] ? cur_r : ((nslot == 6'h00) ? left_w : cur_l);

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctrl    <= `SDI_CTRL_RST;
      ratio   <= `SDI_RATIO_RST;
      left_w  <= '0;
      right_w <= '0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `SDI_REG_CTRL) begin
        ctrl <= reg_wdata_i[4:0];
      end else if (reg_addr_i == `SDI_REG_RATIO) begin
        ratio <= reg_wdata_i[10:0];
      end else if (reg_addr_i == `SDI_REG_LEFT) begin
        left_w <= reg_wdata_i[23:0];
      end else if (reg_addr_i == `SDI_REG_RIGHT) begin
        right_w <= reg_wdata_i[23:0];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !reg_rd_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_addr_i == `SDI_REG_CTRL) begin
      reg_rdata_o <= {27'h0000000, ctrl};
    end else if (reg_addr_i == `SDI_REG_RATIO) begin
      reg_rdata_o <= {21'h000000, ratio};
    end else if (reg_addr_i == `SDI_REG_LEFT) begin
      reg_rdata_o <= {8'h00, left_w};
    end else if (reg_addr_i == `SDI_REG_RIGHT) begin
      reg_rdata_o <= {8'h00, right_w};
    end else if (reg_addr_i == `SDI_REG_STATUS) begin
      reg_rdata_o <= {22'h000000, state, dev_mode2};
    end else begin
      reg_rdata_o <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset and start-up sequence
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !ctrl[`SDI_CTRL_GO]) begin
      state    <= sdi_pkg::SDI_ST_HOLD;
      hold_cnt <= 8'h00;
    end else begin
      case (state)
        sdi_pkg::SDI_ST_HOLD: begin
          // clocks already run; release only after they settle
          if (hold_cnt == 8'(`SDI_RST_HOLD_CYC - 1)) begin
            state <= ctrl[`SDI_CTRL_HOSTMODE] ? sdi_pkg::SDI_ST_WR_EN
                                              : sdi_pkg::SDI_ST_RUN;
          end else begin
            hold_cnt <= hold_cnt + 8'h01;
          end
        end
        sdi_pkg::SDI_ST_WR_EN:  state <= sdi_pkg::SDI_ST_WR_RUN;
        sdi_pkg::SDI_ST_WR_RUN: state <= sdi_pkg::SDI_ST_RUN;
        sdi_pkg::SDI_ST_RUN:    state <= sdi_pkg::SDI_ST_RUN;
        default:                state <= sdi_pkg::SDI_ST_HOLD;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      lnk.dac_reset_n <= 1'b0;
      lnk.cp_wr       <= 1'b0;
      lnk.cp_rd       <= 1'b0;
      lnk.cp_addr     <= 3'h0;
      lnk.cp_wdata    <= 8'h00;
      lnk.speed       <= sdi_pkg::SDI_SPEED_SINGLE;
      rd_q            <= 1'b0;
      dev_mode2       <= 8'h00;
    end else begin
      lnk.dac_reset_n <= state != sdi_pkg::SDI_ST_HOLD;
      lnk.speed       <= sdi_pkg::sdi_speed_e'(ctrl[4:3]);
      lnk.cp_addr     <= `SDI_MODE2_IDX;
      lnk.cp_wr       <= (state == sdi_pkg::SDI_ST_WR_EN) ||
                         (state == sdi_pkg::SDI_ST_WR_RUN);
      lnk.cp_rd       <= state == sdi_pkg::SDI_ST_RUN;
      rd_q            <= lnk.cp_rd;
      if (state == sdi_pkg::SDI_ST_WR_EN) begin
        lnk.cp_wdata <= `SDI_CP_START;
      end else begin
        lnk.cp_wdata <= `SDI_CP_RUN |
                        {6'h00, ctrl[`SDI_CTRL_MDIV], 1'b0};
      end
      if (rd_q) begin
        dev_mode2 <= lnk.cp_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clocks and serial data
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      lnk.master_clock <= 1'b0;
    end else begin
      lnk.master_clock <= !lnk.master_clock;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      hp_cnt                 <= 5'h00;
      slot                   <= 6'h3F;
      cur_l                  <= '0;
      cur_r                  <= '0;
      lnk.bit_clock          <= 1'b0;
      lnk.frame_select_clock <= 1'b0;
      lnk.serial_audio_in    <= 1'b0;
    end else if (hp_cnt != hp - 5'h01) begin
      hp_cnt <= hp_cnt + 5'h01;
    end else begin
      hp_cnt        <= 5'h00;
      lnk.bit_clock <= !lnk.bit_clock;
      // data and frame change on the falling edge
      if (lnk.bit_clock) begin
        slot                   <= nslot;
        lnk.frame_select_clock <= !nslot[5];
        if (nslot == 6'h00) begin
          cur_l <= left_w;
          cur_r <= right_w;
        end
        if (nslot[4:0] < 5'd`SDI_WORD_BITS) begin
          lnk.serial_audio_in <= word[5'd23 - nslot[4:0]];
        end else begin
          lnk.serial_audio_in <= 1'b0;
        end
      end
    end
  end
endmodule : sdi_source

// *** sdi_link_chk.sv ***
`include "sdi_cfg.svh"

module sdi_link_chk (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  // link signals
  input  wire logic       dac_reset_n,
  input  wire logic       serial_audio_in,
  input  wire logic       bit_clock,
  input  wire logic       frame_select_clock,
  input  wire logic       master_clock,
  input  wire logic       cp_wr,
  input  wire logic       cp_rd,
  input  wire logic [2:0] cp_addr,
  input  wire logic [7:0] cp_wdata,
  input  wire logic [7:0] cp_rdata,
  // converter status
  input  wire logic       chan_a_mute_out_o,
  input  wire logic       chan_b_mute_out_o,
  input  wire logic       running_o
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////
  // host-mode start-up writes
  sequence wr_start;
    cp_wr && cp_addr == `SDI_MODE2_IDX && cp_wdata == `SDI_CP_START;
  endsequence

  sequence wr_run;
    cp_wr && cp_addr == `SDI_MODE2_IDX && cp_wdata[7:2] == 6'h08
      && !cp_wdata[0];
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  a_reset_idle: assert property (disable iff (1'b0)
    rst_i |=> !dac_reset_n && !cp_wr && !cp_rd)
    else $error("link not idle after system reset");

  a_rdata_quiet: assert property (
    !cp_rd || !dac_reset_n |=> cp_rdata == 8'h00)
    else $error("control port answered while held or not read");

  a_host_start: assert property (
    $rose(dac_reset_n) && cp_wr |-> wr_start ##1 wr_run ##1 (!cp_wr && cp_rd))
    else $error("host start-up write order wrong");

  a_reset_mute: assert property (
    !dac_reset_n [*4] |-> chan_a_mute_out_o && !running_o)
    else $error("converter not muted while held in reset");

  a_mute_pair: assert property (
    chan_a_mute_out_o == chan_b_mute_out_o)
    else $error("mute outputs differ");

  a_mute_run: assert property (
    running_o && $past(running_o) |-> !chan_a_mute_out_o)
    else $error("mute active while running");

  a_run_cause: assert property (
    running_o |-> $past(dac_reset_n, 2))
    else $error("running without converter reset released");

  a_data_edge: assert property (
    dac_reset_n && $past(dac_reset_n) && $changed(serial_audio_in)
      |-> $fell(bit_clock))
    else $error("serial data moved off the bit clock fall");

  a_frame_edge: assert property (
    dac_reset_n && $past(dac_reset_n) && $changed(frame_select_clock)
      |-> $fell(bit_clock))
    else $error("frame clock moved off the bit clock fall");

  a_mclk_run: assert property (
    !$past(rst_i) |-> master_clock != $past(master_clock))
    else $error("master clock stalled");

endmodule : sdi_link_chk

// *** test_stereo_dac_serial_audio_input.sv ***
`include "sdi_cfg.svh"
`define CHK(nm, exp, got) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); \
  end \
end

module test_stereo_dac_serial_audio_input;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [1:0]  spd;
    logic [10:0] ratio;
    logic        host;
    logic        div;
    logic        run;
  } sdi_row_s;

  logic               clk_sys_i;
  logic               rst_i;
  logic [2:0]         reg_addr_i;
  logic [31:0]        reg_wdata_i;
  logic               reg_wr_i;
  logic               reg_rd_i;
  logic [31:0]        reg_rdata_o;
  logic [31:0]        rd_val;
  logic               sample_ready_i;
  logic               sample_valid_o;
  sdi_pkg::sdi_word_t sample_left_o;
  sdi_pkg::sdi_word_t sample_right_o;
  logic               chan_a_mute_out_o;
  logic               chan_b_mute_out_o;
  logic               running_o;
  logic               overrun_o;
  int                 failures;
  int                 checks;
  int                 n;

  // speed, frame ratio, host mode, divide, expected running
  sdi_row_s rows [21] = '{
    {2'h0,11'h100,3'h1},{2'h0,11'h180,3'h1},{2'h0,11'h200,3'h1},
    {2'h0,11'h300,3'h1},{2'h0,11'h140,3'h0},{2'h0,11'h100,3'h5},
    {2'h0,11'h400,3'h0},{2'h0,11'h400,3'h7},{2'h0,11'h400,3'h4},
    {2'h1,11'h080,3'h1},{2'h1,11'h0C0,3'h1},{2'h1,11'h100,3'h1},
    {2'h1,11'h180,3'h1},{2'h1,11'h200,3'h0},{2'h1,11'h200,3'h7},
    {2'h2,11'h040,3'h1},{2'h2,11'h080,3'h1},{2'h2,11'h0C0,3'h1},
    {2'h2,11'h100,3'h0},{2'h2,11'h100,3'h7},{2'h3,11'h100,3'h0}
  };

  sdi_link_if lnk ();

  sdi_source sdi_source_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .lnk(lnk)
  );

  sdi_dac_input sdi_dac_input_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .lnk(lnk),
    .sample_ready_i(sample_ready_i), .sample_valid_o(sample_valid_o),
    .sample_left_o(sample_left_o), .sample_right_o(sample_right_o),
    .chan_a_mute_out_o(chan_a_mute_out_o),
    .chan_b_mute_out_o(chan_b_mute_out_o),
    .running_o(running_o), .overrun_o(overrun_o)
  );

  sdi_link_chk sdi_link_chk_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .dac_reset_n(lnk.dac_reset_n),
    .serial_audio_in(lnk.serial_audio_in), .bit_clock(lnk.bit_clock),
    .frame_select_clock(lnk.frame_select_clock),
    .master_clock(lnk.master_clock), .cp_wr(lnk.cp_wr), .cp_rd(lnk.cp_rd),
    .cp_addr(lnk.cp_addr), .cp_wdata(lnk.cp_wdata),
    .cp_rdata(lnk.cp_rdata), .chan_a_mute_out_o(chan_a_mute_out_o),
    .chan_b_mute_out_o(chan_b_mute_out_o), .running_o(running_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task automatic reg_wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [2:0] a);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i   <= 1'b0;
    #1;
    rd_val = reg_rdata_o;
  endtask : reg_rd

  // restart the link with a new setting and let three frames pass
  task automatic run_cfg(input sdi_row_s r);
    reg_wr(`SDI_REG_CTRL, 32'h0);
    reg_wr(`SDI_REG_RATIO, {21'h0, r.ratio});
    reg_wr(`SDI_REG_CTRL, {27'h0, r.spd, r.div, r.host, 1'b1});
    repeat (6 * r.ratio + 60) @(posedge clk_sys_i);
    #1;
  endtask : run_cfg

  task automatic final_report;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  // about 70k cycles expected
  initial begin
    repeat (90000) @(posedge clk_sys_i);
    failures++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    failures = 0;
    checks = 0;
    rst_i = 1'b1;
    reg_addr_i = 3'h0;
    reg_wdata_i = 32'h0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    sample_ready_i = 1'b1;
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    reg_rd(`SDI_REG_RATIO);
    `CHK("ratio reset", 32'h100, rd_val)
    foreach (rows[i]) begin
      run_cfg(rows[i]);
      `CHK("running", rows[i].run, running_o)
      `CHK("mute", ~rows[i].run, chan_a_mute_out_o)
      reg_rd(`SDI_REG_STATUS);
      if (rows[i].host) begin
        `CHK("status", {2'h2, 6'h08, rows[i].div, 1'b0}, rd_val[9:0])
      end else begin
        `CHK("status idle", {2'h2, `SDI_MODE2_RST}, rd_val[9:0])
      end
    end
    // fill the buffer with the drain stalled, then empty it
    @(posedge clk_sys_i);
    sample_ready_i <= 1'b0;
    reg_wr(`SDI_REG_LEFT, 32'h00800001);
    reg_wr(`SDI_REG_RIGHT, 32'h007FFFFE);
    run_cfg({2'h0, 11'h100, 3'h1});
    repeat (24 * 512) @(posedge clk_sys_i);
    #1;
    `CHK("full valid", 1'b1, sample_valid_o)
    `CHK("overrun", 1'b1, overrun_o)
    @(posedge clk_sys_i);
    sample_ready_i <= 1'b1;
    n = 0;
    while (n < 40) begin
      @(posedge clk_sys_i);
      #1;
      if (sample_valid_o !== 1'b1) break;
      `CHK("left", 24'h800001, sample_left_o)
      `CHK("right", 24'h7FFFFE, sample_right_o)
      n++;
    end
    `CHK("pairs drained", 1'b1, n >= 16)
    @(posedge clk_sys_i);
    sample_ready_i <= 1'b0;
    repeat (2 * 512) @(posedge clk_sys_i);
    #1;
    `CHK("refill", 1'b1, sample_valid_o)
    `CHK("overrun sticky", 1'b1, overrun_o)
    // system reset in mid-stream
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    #1;
    `CHK("reset running", 1'b0, running_o)
    `CHK("reset mute", 1'b1, chan_b_mute_out_o)
    `CHK("reset valid", 1'b0, sample_valid_o)
    `CHK("reset overrun", 1'b0, overrun_o)
    reg_rd(`SDI_REG_CTRL);
    `CHK("ctrl reset", 32'h0, rd_val)
    reg_rd(3'h7);
    `CHK("unmapped", 32'h0, rd_val)
    final_report();
  end

endmodule : test_stereo_dac_serial_audio_input
